// file: icc_pkg.sv
/*
 * icc_pkg: shared constants and types for the input check configuration
 * block. Assumes nothing beyond a SystemVerilog compiler.
 */
package icc_pkg;

    // register port geometry
    localparam int unsigned ADDR_W    = 7;
    localparam int unsigned REG_W     = 16;
    localparam logic [6:0]  CFG_ADDR  = 7'h01;
    localparam logic [15:0] CFG_RESET = 16'h040e;
    // bits 14, 13 and 0 are never stored and read as zero
    localparam logic [15:0] CFG_WMASK = 16'h9ffe;

    // field positions of the configuration word
    localparam int unsigned B_PATTERN_TEST = 15;
    localparam int unsigned B_AUTO_CLEAR   = 12;
    localparam int unsigned B_PARITY_ODD   = 11;
    localparam int unsigned B_PARITY_ENA   = 10;
    localparam int unsigned B_PARITY_DUAL  = 9;
    localparam int unsigned B_REV_IFACE    = 8;
    localparam int unsigned B_CHAN_A_INV   = 7;
    localparam int unsigned B_CHAN_D_INV   = 4;
    localparam int unsigned B_GAP_TWO_ENA  = 3;
    localparam int unsigned B_GAP_ONE_ENA  = 2;
    localparam int unsigned B_COLLIDE_ENA  = 1;

    // data path geometry
    localparam int unsigned BUS_W   = 32;
    localparam int unsigned CHAN_W  = 16;
    localparam int unsigned N_CHAN  = 4;
    localparam int unsigned SIDE_W  = 6;
    localparam int unsigned PIN_W   = BUS_W + SIDE_W + 1;

    // good-sample run that clears latched alarms
    localparam logic [6:0] GOOD_RUN = 7'd64;

    // pattern checker expects this 8-word loop, restarted by sync
    localparam int unsigned PAT_N = 8;
    localparam logic [7:0][31:0] PATTERN = {
        32'h7a7a_b6b6, 32'hb6b6_7a7a, 32'heaea_4545, 32'h4545_eaea,
        32'h1a1a_1616, 32'h1616_1a1a, 32'haaaa_c6c6, 32'hc6c6_aaaa};

    // side inputs: two half-cycle samples per pin pair
    typedef struct packed {
        logic [1:0] parity;
        logic [1:0] sync;
        logic [1:0] strobe;
    } icc_side_t;

    // latched alarm flags
    typedef struct packed {
        logic pattern;
        logic parity;
        logic gap_two;
        logic gap_one;
        logic collision;
    } icc_alarm_t;

    typedef enum logic [2:0] {
        LANE_WAIT = 3'b001,
        LANE_AB   = 3'b010,
        LANE_CD   = 3'b100
    } icc_lane_t;

endpackage

// file: icc_sync2.sv
/*
 * icc_sync2: two-flop synchroniser for pin inputs.
 * Assumes the inputs are quasi-static relative to clock_i or that the
 * source is source-synchronous so a one-cycle skew is harmless.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage is read only by the second stage
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule
`default_nettype wire

// file: icc_parity.sv
/*
 * icc_parity: combinational single/dual parity check of one bus word.
 * Assumes the caller registers the error result.
 */
`timescale 1ns/1ps
`default_nettype none
module icc_parity (
    input  wire logic [31:0] word_i,
    input  wire logic [1:0]  par_i,
    input  wire logic        enable_i,
    input  wire logic        dual_i,
    input  wire logic        odd_i,
    output logic             error_o
);

    logic err_hi;
    logic err_lo;
    logic err_all;

    // sense selects check
    // ones in data plus parity bit must be even (0) or odd (1)
    assign err_hi  = (^{word_i[31:16], par_i[1]}) ^ odd_i;
    assign err_lo  = (^{word_i[15:0], par_i[0]}) ^ odd_i;
    assign err_all = (^{word_i, par_i[0]}) ^ odd_i;

    always_comb begin
        if (!enable_i) begin
            error_o = 1'b0;
        end else if (dual_i) begin
            error_o = err_hi | err_lo;
        end else begin
            error_o = err_all;
        end
    end

endmodule
`default_nettype wire

// file: icc_input_interface_check_config.sv
/*
 * icc_input_interface_check_config: the input-side configuration word
 * and the logic it steers: pattern checker, parity check, side input
 * rotation, channel inversion, FIFO alarm enables and alarm auto-clear.
 * Assumes a serial interface decoder on clock_i drives the register
 * port, FIFO pointer comparators on clock_i drive the gap events, and
 * the data bus and side pairs arrive as pins from outside this clock.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - pattern-test bit runs the input pattern checker instead of normal use
// - pattern test keeps outputs off despite both transmit enables
// - auto-clear bit clears latched alarms after 64 consecutive good samples
// - parity sense: zero checks even parity, one checks odd
// - parity enable checks every word against parity pair; resets to one
// - dual bit selects dual parity, otherwise single parity
// - dual parity acts only while parity enable is set
// - reversal bit: sync acts as strobe, parity as sync, strobe as parity
// - bits 7 to 4 invert channel A to D output codes
// - enable bit passes the pointers-two-apart FIFO alarm
// - enable bit passes the pointers-one-apart FIFO alarm
// - enable bit passes the pointer collision FIFO alarm
// - register at 0x01 resets to 0x040e
module icc_input_interface_check_config (
    input  wire logic                     clock_i,
    input  wire logic                     srst_i,
    // register port from the serial interface decoder
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [6:0]               reg_addr_i,
    input  wire logic [15:0]              reg_wdata_i,
    output logic      [15:0]              reg_rdata_o,
    // pins from the data source
    input  wire logic [31:0]              data_bus_i,
    input  wire logic [1:0]               parity_input_pair_i,
    input  wire logic [1:0]               sync_input_pair_i,
    input  wire logic [1:0]               frame_strobe_pair_i,
    input  wire logic                     transmit_enable_pin_i,
    // same-clock controls and FIFO events
    input  wire logic                     sif_tx_enable_i,
    input  wire logic                     alarm_clear_i,
    input  wire logic                     fifo_gap_two_i,
    input  wire logic                     fifo_gap_one_i,
    input  wire logic                     fifo_collision_i,
    // results
    output logic      [15:0]              chan_a_o,
    output logic      [15:0]              chan_b_o,
    output logic      [15:0]              chan_c_o,
    output logic      [15:0]              chan_d_o,
    output logic                          outputs_active_o,
    output icc_pkg::icc_alarm_t           alarm_o
);

    logic [15:0]          cfg_ff;
    logic [15:0]          rdata_ff;
    logic [38:0]          pins_sync;
    logic [31:0]          word;
    icc_pkg::icc_side_t   side_pin;
    icc_pkg::icc_side_t   side_fn;
    logic                 tx_pin;
    icc_pkg::icc_lane_t   lane_ff;
    icc_pkg::icc_lane_t   nxt_lane;
    logic [2:0]           pat_idx_ff;
    logic                 pattern_err;
    logic                 parity_err;
    logic                 sample_bad;
    logic [6:0]           good_cnt_ff;
    logic                 auto_clear;
    icc_pkg::icc_alarm_t  alarm_ff;
    icc_pkg::icc_alarm_t  alarm_set;
    logic                 active_ff;
    logic [3:0][15:0]     chan_ff;
    logic [3:0]           chan_inv;
    logic                 test_on;

    // configuration fields
    assign test_on = cfg_ff[icc_pkg::B_PATTERN_TEST];
    assign chan_inv = cfg_ff[icc_pkg::B_CHAN_A_INV:icc_pkg::B_CHAN_D_INV];

    // every pin passes two flops before any logic looks at it
    icc_sync2 #(
        .W (icc_pkg::PIN_W)
    ) u_pin_sync (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .async_i ({transmit_enable_pin_i, parity_input_pair_i,
                   sync_input_pair_i, frame_strobe_pair_i, data_bus_i}),
        .sync_o  (pins_sync)
    );

    assign word            = pins_sync[31:0];
    assign side_pin.strobe = pins_sync[33:32];
    assign side_pin.sync   = pins_sync[35:34];
    assign side_pin.parity = pins_sync[37:36];
    assign tx_pin          = pins_sync[38];

    // reserved bits dropped
    // reserved bits are masked on write so they can never steer logic
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg_ff <= icc_pkg::CFG_RESET;
        end else if (reg_wr_i && reg_addr_i == icc_pkg::CFG_ADDR) begin
            cfg_ff <= reg_wdata_i & icc_pkg::CFG_WMASK;
        end
    end

    // read answer one cycle after the strobe; other addresses read zero
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == icc_pkg::CFG_ADDR) begin
                rdata_ff <= cfg_ff;
            end else begin
                rdata_ff <= 16'h0000;
            end
        end
    end

    // side input rotation
    // a reversed bus also swaps which pair carries which function
    always_comb begin
        if (cfg_ff[icc_pkg::B_REV_IFACE]) begin
            side_fn.strobe = side_pin.sync;
            side_fn.sync   = side_pin.parity;
            side_fn.parity = side_pin.strobe;
        end else begin
            side_fn = side_pin;
        end
    end

    // lane tracker: word with strobe is A/B, the next one C/D
    always_comb begin
        nxt_lane = lane_ff;
        unique case (lane_ff)
            icc_pkg::LANE_WAIT: begin
                if (side_fn.strobe[0]) begin
                    nxt_lane = icc_pkg::LANE_CD;
                end
            end
            icc_pkg::LANE_AB: begin
                nxt_lane = icc_pkg::LANE_CD;
            end
            icc_pkg::LANE_CD: begin
                nxt_lane = icc_pkg::LANE_AB;
            end
        endcase
        // a strobe always realigns, so a lost word costs one pair
        if (side_fn.strobe[0]) begin
            nxt_lane = icc_pkg::LANE_CD;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            lane_ff <= icc_pkg::LANE_WAIT;
        end else begin
            lane_ff <= nxt_lane;
        end
    end

    // pattern checker index
    // sync restarts the loop so source and checker agree on word zero
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pat_idx_ff <= 3'h0;
        end else if (!test_on || side_fn.sync[0]) begin
            pat_idx_ff <= 3'h1;
        end else begin
            pat_idx_ff <= pat_idx_ff + 3'h1;
        end
    end

    always_comb begin
        pattern_err = 1'b0;
        if (test_on) begin
            if (side_fn.sync[0]) begin
                pattern_err = word != icc_pkg::PATTERN[0];
            end else begin
                pattern_err = word != icc_pkg::PATTERN[pat_idx_ff];
            end
        end
    end

    icc_parity u_parity (
        .word_i   (word),
        .par_i    (side_fn.parity),
        .enable_i (cfg_ff[icc_pkg::B_PARITY_ENA]),
        .dual_i   (cfg_ff[icc_pkg::B_PARITY_DUAL]),
        .odd_i    (cfg_ff[icc_pkg::B_PARITY_ODD]),
        .error_o  (parity_err)
    );

    assign sample_bad = pattern_err | parity_err;

    // good-sample run counter
    // counter saturates at the run length unless auto-clear fires and restarts it; any bad word starts it over
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            good_cnt_ff <= 7'h00;
        end else if (sample_bad || auto_clear) begin
            good_cnt_ff <= 7'h00;
        end else if (good_cnt_ff != icc_pkg::GOOD_RUN) begin
            good_cnt_ff <= good_cnt_ff + 7'h01;
        end
    end

    assign auto_clear = cfg_ff[icc_pkg::B_AUTO_CLEAR]
                        && good_cnt_ff == icc_pkg::GOOD_RUN;

    always_comb begin
        alarm_set.pattern   = pattern_err;
        alarm_set.parity    = parity_err;
        alarm_set.gap_two   = fifo_gap_two_i
                              & cfg_ff[icc_pkg::B_GAP_TWO_ENA];
        alarm_set.gap_one   = fifo_gap_one_i
                              & cfg_ff[icc_pkg::B_GAP_ONE_ENA];
        alarm_set.collision = fifo_collision_i
                              & cfg_ff[icc_pkg::B_COLLIDE_ENA];
    end

    // latched alarms cleared
    // a new event in the clearing cycle wins, so it is never lost
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            alarm_ff <= '0;
        end else if (alarm_clear_i || auto_clear) begin
            alarm_ff <= alarm_set;
        end else begin
            alarm_ff <= alarm_ff | alarm_set;
        end
    end

    // outputs off in test
    // pattern test overrides both the pin and the serial enable
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= tx_pin && sif_tx_enable_i && !test_on;
        end
    end

    // channel inversion
    // channel A is index 3 so it lines up with config bit 7
    generate
        for (genvar c = 0; c < 4; c++) begin : g_chan
            localparam bit IS_AB = (c >= 2);
            localparam int unsigned HI = (c % 2) * 16;
            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    chan_ff[c] <= 16'h0000;
                end else if (test_on) begin
                    chan_ff[c] <= 16'h0000;
                end else if ((IS_AB && nxt_lane == icc_pkg::LANE_CD
                              && lane_ff != icc_pkg::LANE_CD)
                             || (!IS_AB && lane_ff == icc_pkg::LANE_CD)) begin
                    chan_ff[c] <= word[HI+:16] ^ {16{chan_inv[c]}};
                end
            end
        end
    endgenerate

    // registered outputs
    assign reg_rdata_o      = rdata_ff;
    assign alarm_o          = alarm_ff;
    assign outputs_active_o = active_ff;
    assign chan_a_o         = chan_ff[3];
    assign chan_b_o         = chan_ff[2];
    assign chan_c_o         = chan_ff[1];
    assign chan_d_o         = chan_ff[0];

endmodule
`default_nettype wire

// file: icc_check_properties.sv
/* port-level properties of the input check block.
   bound below to every instance of the top module, one clock. */
`timescale 1ns/1ps
`default_nettype none
module icc_check_properties (
    input wire logic                clock_i,
    input wire logic                srst_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [6:0]          reg_addr_i,
    input wire logic [15:0]         reg_wdata_i,
    input wire logic [15:0]         reg_rdata_o,
    input wire logic                transmit_enable_pin_i,
    input wire logic                sif_tx_enable_i,
    input wire logic                fifo_gap_two_i,
    input wire logic                fifo_collision_i,
    input wire logic [15:0]         chan_a_o,
    input wire logic                outputs_active_o,
    input wire icc_pkg::icc_alarm_t alarm_o
);
    logic [15:0] cfg_ff;

    // shadow of the stored word, so properties know the live settings
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg_ff <= 16'h040e;
        end else if (reg_wr_i && reg_addr_i == 7'h01) begin
            cfg_ff <= reg_wdata_i & 16'h9ffe;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    AST_RESET_QUIET: assert property ($fell(srst_i) |->
        reg_rdata_o == 16'h0000 && alarm_o == '0 && !outputs_active_o)
        else $error("outputs not quiet after reset");
    AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i != 7'h01
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    AST_READ_BACK: assert property (reg_rd_i && reg_addr_i == 7'h01
        |=> reg_rdata_o == $past(cfg_ff)) else $error("read back wrong");
    AST_RSVD_ZERO: assert property (reg_rd_i |=>
        reg_rdata_o[14:13] == 2'b00 && !reg_rdata_o[0])
        else $error("reserved bits read set");
    AST_TEST_SILENT: assert property (cfg_ff[15] |=>
        !outputs_active_o && chan_a_o == 16'h0000)
        else $error("outputs live in pattern test");
    AST_TX_ACTIVE: assert property ((sif_tx_enable_i &&
        transmit_enable_pin_i && !cfg_ff[15]) [*4] |=> outputs_active_o)
        else $error("outputs not active");
    AST_SIF_OFF: assert property (!sif_tx_enable_i |=>
        !outputs_active_o) else $error("outputs on without enable");
    AST_GAP_TWO: assert property (fifo_gap_two_i && cfg_ff[3]
        |=> alarm_o.gap_two) else $error("gap two alarm missed");
    AST_GAP_ONE_OFF: assert property (!cfg_ff[2] && !alarm_o.gap_one
        |=> !alarm_o.gap_one) else $error("gap one alarm not masked");
    AST_COLLIDE: assert property (fifo_collision_i && cfg_ff[1]
        |=> alarm_o.collision) else $error("collision alarm missed");
endmodule

bind icc_input_interface_check_config icc_check_properties i_chk (
    .clock_i(clock_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .transmit_enable_pin_i(transmit_enable_pin_i),
    .sif_tx_enable_i(sif_tx_enable_i), .fifo_gap_two_i(fifo_gap_two_i),
    .fifo_collision_i(fifo_collision_i), .chan_a_o(chan_a_o),
    .outputs_active_o(outputs_active_o), .alarm_o(alarm_o));
`default_nettype wire

// file: icc_data_source.sv
/* data source model for the parallel input pins.
   assumes the bench changes its inputs at the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module icc_data_source (
    input  wire logic [31:0] word_i,
    input  wire logic        mark_i,
    input  wire logic        odd_i,
    input  wire logic        dual_i,
    input  wire logic        rev_i,
    input  wire logic        bad_i,
    output logic      [31:0] data_bus_o,
    output logic      [1:0]  parity_o,
    output logic      [1:0]  sync_o,
    output logic      [1:0]  strobe_o
);
    logic [1:0] par;

    // parity made with the selected sense; bad_i breaks it on purpose
    assign par[1] = ^word_i[31:16] ^ odd_i ^ bad_i;
    assign par[0] = (dual_i ? ^word_i[15:0] : ^word_i) ^ odd_i ^ bad_i;

    // reversed board: functions leave on the rotated pairs
    assign data_bus_o = word_i;
    assign sync_o     = {2{mark_i}};
    assign parity_o   = rev_i ? {2{mark_i}} : par;
    assign strobe_o   = rev_i ? par : {2{mark_i}};
endmodule
`default_nettype wire

// file: icc_input_interface_check_config_tb_top.sv
/* self-checking bench for the input check configuration block.
   assumes the checker file is compiled alongside for its bind. */
`timescale 1ns/1ps
`default_nettype none
module icc_input_interface_check_config_tb_top;
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rd;
        logic        bad;
    } icc_row_t;
    // written word, expected read back, parity broken by the source
    localparam icc_row_t ROWS [0:5] = '{
        '{16'h040e, 16'h040e, 1'b0}, '{16'h0ef0, 16'h0ef0, 1'b0},
        '{16'h66a1, 16'h06a0, 1'b0}, '{16'h8450, 16'h8450, 1'b0},
        '{16'h0350, 16'h0350, 1'b1}, '{16'h0d80, 16'h0d80, 1'b1}};

    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        wr = 1'b0, rd_s = 1'b0, clr = 1'b0, tx = 1'b1;
    logic        sif = 1'b1, mark = 1'b0, bad = 1'b0, t;
    logic [2:0]  ev = 3'b000;
    logic [6:0]  addr = 7'h00;
    logic [15:0] wdata = 16'h0000, scfg = 16'h040e, rdata, c;
    logic [15:0] ca, cb, cc, cd;
    logic [31:0] word, bus;
    logic [1:0]  par_p, sync_p, strb_p;
    logic        act;
    icc_pkg::icc_alarm_t alarm;
    int          fails = 0;
    int          checks = 0;

    always #50 clock_i = ~clock_i;
    // strobe and sync mark every other word, which is the A/B word
    always @(negedge clock_i) mark <= ~mark;
    assign word = mark ? 32'h1234_a5c3 : 32'h0ff0_8001;

    icc_data_source i_icc_data_source (.word_i(word), .mark_i(mark),
        .odd_i(scfg[11]), .dual_i(scfg[9]), .rev_i(scfg[8]), .bad_i(bad),
        .data_bus_o(bus), .parity_o(par_p), .sync_o(sync_p),
        .strobe_o(strb_p));

    icc_input_interface_check_config i_icc_input_interface_check_config (
        .clock_i(clock_i), .srst_i(srst_i), .reg_wr_i(wr),
        .reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .data_bus_i(bus), .parity_input_pair_i(par_p),
        .sync_input_pair_i(sync_p), .frame_strobe_pair_i(strb_p),
        .transmit_enable_pin_i(tx), .sif_tx_enable_i(sif),
        .alarm_clear_i(clr), .fifo_gap_two_i(ev[2]),
        .fifo_gap_one_i(ev[1]), .fifo_collision_i(ev[0]),
        .chan_a_o(ca), .chan_b_o(cb), .chan_c_o(cc), .chan_d_o(cd),
        .outputs_active_o(act), .alarm_o(alarm));

    task automatic cmp(input string what, input logic [15:0] exp, got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // every request is raised at one falling edge, dropped at the next
    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(negedge clock_i);
        wr = 1'b1;
        addr = a;
        wdata = d;
        if (a == 7'h01) begin
            scfg = d;
        end
        @(negedge clock_i);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [6:0] a, input logic [15:0] exp);
        @(negedge clock_i);
        rd_s = 1'b1;
        addr = a;
        @(negedge clock_i);
        rd_s = 1'b0;
        cmp("rdata", exp, rdata);
    endtask

    task automatic pulse(input logic [2:0] e, input logic cl);
        @(negedge clock_i);
        ev = e;
        clr = cl;
        @(negedge clock_i);
        ev = 3'b000;
        clr = 1'b0;
    endtask

    // a hang is cut short well inside the cycle budget
    initial begin
        #5_000_000;
        fails++;
        end_sim;
    end

    initial begin
        repeat (12) @(negedge clock_i);
        srst_i = 1'b0;
        cmp("alarm", 16'h0000, {11'h000, alarm});
        rd_reg(7'h01, 16'h040e);
        foreach (ROWS[i]) begin
            c = ROWS[i].cfg;
            t = c[15];
            bad = ROWS[i].bad;
            wr_reg(7'h01, c);
            rd_reg(7'h01, ROWS[i].rd);
            // settle the pin pipeline before clearing stale alarms
            repeat (6) @(negedge clock_i);
            pulse(3'b000, 1'b1);
            repeat (8) @(negedge clock_i);
            cmp("chan_a", t ? 16'h0 : 16'h1234 ^ {16{c[7]}}, ca);
            cmp("chan_b", t ? 16'h0 : 16'ha5c3 ^ {16{c[6]}}, cb);
            cmp("chan_c", t ? 16'h0 : 16'h0ff0 ^ {16{c[5]}}, cc);
            cmp("chan_d", t ? 16'h0 : 16'h8001 ^ {16{c[4]}}, cd);
            cmp("active", {15'h0, !t}, {15'h0, act});
            cmp("alarm", {11'h0, t, bad & c[10], 3'h0},
                {11'h0, alarm});
        end
        bad = 1'b0;
        wr_reg(7'h01, 16'h0000);
        // the last row left a parity flag latched
        pulse(3'b000, 1'b1);
        pulse(3'b111, 1'b0);
        cmp("alarm", 16'h0000, {11'h000, alarm});
        wr_reg(7'h01, 16'h000e);
        pulse(3'b111, 1'b0);
        cmp("alarm", 16'h0007, {11'h000, alarm});
        // a new event in the clearing cycle keeps its flag
        pulse(3'b001, 1'b1);
        cmp("alarm", 16'h0001, {11'h000, alarm});
        // let the good-word counter saturate so auto-clear fires at once
        repeat (70) @(negedge clock_i);
        wr_reg(7'h01, 16'h100e);
        repeat (3) @(negedge clock_i);
        pulse(3'b100, 1'b0);
        repeat (55) @(negedge clock_i);
        cmp("alarm", 16'h0004, {11'h000, alarm});
        repeat (15) @(negedge clock_i);
        cmp("alarm", 16'h0000, {11'h000, alarm});
        tx = 1'b0;
        repeat (5) @(negedge clock_i);
        cmp("active", 16'h0000, {15'h0, act});
        tx = 1'b1;
        sif = 1'b0;
        repeat (5) @(negedge clock_i);
        cmp("active", 16'h0000, {15'h0, act});
        sif = 1'b1;
        wr_reg(7'h02, 16'hffff);
        rd_reg(7'h02, 16'h0000);
        rd_reg(7'h01, 16'h100e);
        // mid-run reset returns every register to its reset value
        srst_i = 1'b1;
        scfg = 16'h040e;
        repeat (3) @(negedge clock_i);
        srst_i = 1'b0;
        cmp("chan_a", 16'h0000, ca);
        cmp("alarm", 16'h0000, {11'h000, alarm});
        cmp("active", 16'h0000, {15'h0, act});
        rd_reg(7'h01, 16'h040e);
        end_sim;
    end
endmodule
`default_nettype wire
